// >>> core/ch4_cc_pkg.sv
package ch4_cc_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] ADDR_IO_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ADC_CTRL = 8'h08;
  localparam logic [7:0] ADDR_GEN_A = 8'h0C;
  localparam logic [7:0] ADDR_GEN_B = 8'h10;
  localparam logic [7:0] ADDR_COUNTER = 8'h14;
  // ****************
  // Field positions and reset values
  // ****************
  localparam int IO_B_LSB = 4;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam int OVF_BIT = 4;
  localparam int UNF_BIT = 5;
  localparam int DIR_BIT = 7;
  localparam int ADC_EN_BIT = 7;
  localparam logic [7:0] IO_CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [15:0] GEN_RST = 16'hFFFF;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [31:0] PRDATA_UNMAPPED = 32'h00000000;
endpackage

// >>> core/ch4_edge_sync.sv
`timescale 1ns/100ps
module ch4_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // Three stages; a change counts once stage two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
  assign fall = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule // ch4_edge_sync

// >>> core/ch4_cc_unit.sv
`timescale 1ns/100ps
module ch4_cc_unit
  import ch4_cc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] mode,
  input wire logic [15:0] count,
  input wire logic [15:0] gen,
  input wire logic pin_rise,
  input wire logic pin_fall,
  input wire logic chain_event,
  output logic match,
  output logic capture,
  output logic pin_out,
  output logic pin_oe
);
  logic [3:0] mode_q_r;
  logic match_d_r;
  logic is_cmp;

  assign is_cmp = !mode[3];
  assign match = is_cmp && (count == gen) && !match_d_r;
  // Capture source: pin edges or chained channel event
  always_comb begin
    case (mode[3:2])
      2'b10: begin
        if (mode[1]) begin
          capture = pin_rise || pin_fall;
        end else if (mode[0]) begin
          capture = pin_fall;
        end else begin
          capture = pin_rise;
        end
      end
      2'b11: capture = chain_event;
      default: capture = 1'b0;
    endcase
  end

  // Match is one pulse per equal spell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_d_r <= 1'b0;
    end else begin
      match_d_r <= is_cmp && (count == gen);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q_r <= 4'h0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      mode_q_r <= mode;
      pin_oe <= is_cmp && (mode[1:0] != 2'b00);
      if (mode != mode_q_r) begin
        pin_out <= mode[2];
      end else if (match) begin
        case (mode[1:0])
          2'b01: pin_out <= 1'b0;
          2'b10: pin_out <= 1'b1;
          2'b11: pin_out <= !pin_out;
          default: pin_out <= pin_out;
        endcase
      end
    end
  end
endmodule // ch4_cc_unit

// >>> core/ch4_cc_ctrl.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module ch4_cc_ctrl
  import ch4_cc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_counter,
  input wire logic count_direction_flag,
  input wire logic overflow_evt,
  input wire logic underflow_evt,
  input wire logic ch3_event_a,
  input wire logic ch3_event_c,
  input wire logic dtc_start_a,
  input wire logic dtc_start_b,
  input wire logic transfer_irq_disable_select_a,
  input wire logic transfer_irq_disable_select_b,
  input wire logic ch4_pin_a_in,
  input wire logic ch4_pin_b_in,
  output logic ch4_pin_a_out,
  output logic ch4_pin_a_oe,
  output logic ch4_pin_b_out,
  output logic ch4_pin_b_oe,
  output logic match_capture_irq_a,
  output logic match_capture_irq_b,
  output logic adc_start
);
  // ****************
  // Registers
  // ****************
  logic [7:0] io_ctrl_r;
  logic adc_en_r;
  logic [15:0] ch4_general_reg_a;
  logic [15:0] ch4_general_reg_b;
  logic match_capture_flag_a;
  logic match_capture_flag_b;
  logic overflow_flag;
  logic underflow_flag;
  logic [1:0] armed_r;
  logic [1:0] ovf_armed_r;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [1:0] evt;
  logic [1:0] match_p;
  logic [1:0] cap_p;
  logic [1:0] clr;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [7:0] status;
  logic [3:0] mode_a;
  logic [3:0] mode_b;

  assign mode_a = io_ctrl_r[3:0];
  assign mode_b = io_ctrl_r[IO_B_LSB +: 4];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == ADDR_IO_CTRL) || (paddr == ADDR_STATUS) ||
    (paddr == ADDR_ADC_CTRL) || (paddr == ADDR_GEN_A) || (paddr == ADDR_GEN_B) ||
    (paddr == ADDR_COUNTER);
  assign pslverr = psel && penable && !mapped;
  assign status = {count_direction_flag, 1'b1, underflow_flag, overflow_flag, 2'b00,
    match_capture_flag_b, match_capture_flag_a};

  // ****************
  // Pin edge detection
  // ****************
  ch4_edge_sync u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ch4_pin_a_in),
    .rise(rise[0]),
    .fall(fall[0])
  );

  ch4_edge_sync u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ch4_pin_b_in),
    .rise(rise[1]),
    .fall(fall[1])
  );

  // ****************
  // Compare/capture units
  // ****************
  ch4_cc_unit u_unit_a (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode_a),
    .count(timer_counter),
    .gen(ch4_general_reg_a),
    .pin_rise(rise[0]),
    .pin_fall(fall[0]),
    .chain_event(ch3_event_a),
    .match(match_p[0]),
    .capture(cap_p[0]),
    .pin_out(ch4_pin_a_out),
    .pin_oe(ch4_pin_a_oe)
  );

  ch4_cc_unit u_unit_b (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode_b),
    .count(timer_counter),
    .gen(ch4_general_reg_b),
    .pin_rise(rise[1]),
    .pin_fall(fall[1]),
    .chain_event(ch3_event_c),
    .match(match_p[1]),
    .capture(cap_p[1]),
    .pin_out(ch4_pin_b_out),
    .pin_oe(ch4_pin_b_oe)
  );

  assign evt = match_p | cap_p;
  assign clr[0] = (dtc_start_a && !transfer_irq_disable_select_a) ||
    (wr_en && paddr == ADDR_STATUS && !pwdata[FLAG_A_BIT] && armed_r[0]);
  assign clr[1] = (dtc_start_b && !transfer_irq_disable_select_b) ||
    (wr_en && paddr == ADDR_STATUS && !pwdata[FLAG_B_BIT] && armed_r[1]);

  // ****************
  // Control registers
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_ctrl_r <= IO_CTRL_RST;
      adc_en_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == ADDR_IO_CTRL) begin
        io_ctrl_r <= pwdata[7:0];
      end
      if (paddr == ADDR_ADC_CTRL) begin
        adc_en_r <= pwdata[ADC_EN_BIT];
      end
    end
  end

  // ****************
  // General registers: capture wins over a bus write
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch4_general_reg_a <= GEN_RST;
      ch4_general_reg_b <= GEN_RST;
    end else begin
      if (cap_p[0]) begin
        ch4_general_reg_a <= timer_counter;
      end else if (wr_en && paddr == ADDR_GEN_A) begin
        ch4_general_reg_a <= pwdata[15:0];
      end
      if (cap_p[1]) begin
        ch4_general_reg_b <= timer_counter;
      end else if (wr_en && paddr == ADDR_GEN_B) begin
        ch4_general_reg_b <= pwdata[15:0];
      end
    end
  end

  // ****************
  // Status flags: set wins over clear
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_capture_flag_a <= STATUS_RST[FLAG_A_BIT];
      match_capture_flag_b <= STATUS_RST[FLAG_B_BIT];
      armed_r <= 2'b00;
    end else begin
      if (evt[0]) begin
        match_capture_flag_a <= 1'b1;
      end else if (clr[0]) begin
        match_capture_flag_a <= 1'b0;
      end
      if (evt[1]) begin
        match_capture_flag_b <= 1'b1;
      end else if (clr[1]) begin
        match_capture_flag_b <= 1'b0;
      end
      if (rd_en && paddr == ADDR_STATUS) begin
        armed_r <= {match_capture_flag_b, match_capture_flag_a};
      end else begin
        armed_r <= armed_r & ~clr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= STATUS_RST[OVF_BIT];
      underflow_flag <= STATUS_RST[UNF_BIT];
      ovf_armed_r <= 2'b00;
    end else begin
      if (overflow_evt) begin
        overflow_flag <= 1'b1;
      end else if (wr_en && paddr == ADDR_STATUS && !pwdata[OVF_BIT] && ovf_armed_r[0]) begin
        overflow_flag <= 1'b0;
      end
      if (underflow_evt) begin
        underflow_flag <= 1'b1;
      end else if (wr_en && paddr == ADDR_STATUS && !pwdata[UNF_BIT] && ovf_armed_r[1]) begin
        underflow_flag <= 1'b0;
      end
      if (rd_en && paddr == ADDR_STATUS) begin
        ovf_armed_r <= {underflow_flag, overflow_flag};
      end else if (wr_en && paddr == ADDR_STATUS) begin
        ovf_armed_r <= ovf_armed_r & pwdata[UNF_BIT:OVF_BIT];
      end
    end
  end

  // ****************
  // Outputs
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= adc_en_r && evt[0];
    end
  end

  assign match_capture_irq_a = match_capture_flag_a;
  assign match_capture_irq_b = match_capture_flag_b;

  always_comb begin
    prdata = PRDATA_UNMAPPED;
    case (paddr)
      ADDR_IO_CTRL: prdata = {24'h000000, io_ctrl_r};
      ADDR_STATUS: prdata = {24'h000000, status};
      ADDR_ADC_CTRL: prdata = {24'h000000, adc_en_r, 7'h00};
      ADDR_GEN_A: prdata = {16'h0000, ch4_general_reg_a};
      ADDR_GEN_B: prdata = {16'h0000, ch4_general_reg_b};
      ADDR_COUNTER: prdata = {16'h0000, timer_counter};
      default: prdata = PRDATA_UNMAPPED;
    endcase
  end

  // ****************
  // Checks
  // ****************
  AST_ADC_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |-> $past(adc_en_r)) else $error("conversion start while disabled");
  AST_ADC_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    (adc_en_r && evt[0]) |=> adc_start) else $error("missing conversion start");
  AST_SET_A: assert property (@(posedge pclk) disable iff (!presetn)
    match_p[0] |=> match_capture_flag_a) else $error("flag A not set on match");
  AST_CAP_A: assert property (@(posedge pclk) disable iff (!presetn)
    cap_p[0] |=> (ch4_general_reg_a == $past(timer_counter)) && match_capture_flag_a)
    else $error("capture A failed");
  AST_DTC_A: assert property (@(posedge pclk) disable iff (!presetn)
    (dtc_start_a && !transfer_irq_disable_select_a && !evt[0]) |=> !match_capture_flag_a)
    else $error("flag A not cleared by transfer");
  AST_NOCLR_A: assert property (@(posedge pclk) disable iff (!presetn)
    (match_capture_flag_a && !armed_r[0] && !dtc_start_a) |=> match_capture_flag_a)
    else $error("flag A cleared without read");
  AST_ONE_A: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_STATUS && pwdata[FLAG_A_BIT] && !dtc_start_a &&
    match_capture_flag_a) |=> match_capture_flag_a) else $error("write one cleared A");
  AST_SET_B: assert property (@(posedge pclk) disable iff (!presetn)
    evt[1] |=> match_capture_flag_b) else $error("flag B not set");
  AST_CHAIN_A: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_a[3:2] == 2'b11 && ch3_event_a) |-> cap_p[0]) else $error("chain A missed");
  AST_CHAIN_B: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_b[3:2] == 2'b11 && ch3_event_c) |-> cap_p[1]) else $error("chain B missed");
  AST_TOGGLE_A: assert property (@(posedge pclk) disable iff (!presetn)
    (match_p[0] && mode_a == $past(mode_a) && mode_a[1:0] == 2'b11 &&
    u_unit_a.mode_q_r == mode_a) |=> ch4_pin_a_out != $past(ch4_pin_a_out))
    else $error("pin A no toggle");
  AST_EDGE_B: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_b == 4'h8 && rise[1]) |-> cap_p[1]) else $error("B rise missed");
  AST_OUT_B: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_b[3] == 1'b0 && mode_b[1:0] == 2'b00) |=> !ch4_pin_b_oe)
    else $error("B pin driven while disabled");
  AST_EDGE_A: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_a == 4'h9 && fall[0]) |-> cap_p[0]) else $error("A fall missed");
  COV_MATCH_A: cover property (@(posedge pclk) match_p[0]);
  COV_CAP_B: cover property (@(posedge pclk) cap_p[1]);
  COV_SW_CLR: cover property (@(posedge pclk) clr[0] && !dtc_start_a);
  COV_ADC: cover property (@(posedge pclk) adc_start);
endmodule // ch4_cc_ctrl

// >>> testbench/ch4_far_model.sv
`timescale 1ns/100ps
// ****************
// Far side: free counter, pins, channel 3 events
// ****************
module ch4_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic pin_a_drv,
  input wire logic pin_b_drv,
  input wire logic ev_a_req,
  input wire logic ev_c_req,
  output logic [15:0] counter,
  output logic pin_a,
  output logic pin_b,
  output logic ch3_event_a,
  output logic ch3_event_c
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= 16'h0000;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      ch3_event_a <= 1'b0;
      ch3_event_c <= 1'b0;
    end else begin
      if (load) begin
        counter <= load_val;
      end else if (run) begin
        counter <= counter + 16'h0001;
      end
      pin_a <= pin_a_drv;
      pin_b <= pin_b_drv;
      ch3_event_a <= ev_a_req;
      ch3_event_c <= ev_c_req;
    end
  end
endmodule // ch4_far_model

// >>> testbench/timer_ch4_capture_compare_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module timer_ch4_capture_compare_ctrl_tb_top;
  import ch4_cc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, serr;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0000;
  logic pin_a_drv = 1'b0;
  logic pin_b_drv = 1'b0;
  logic ev_a_req = 1'b0;
  logic ev_c_req = 1'b0;
  logic dtc_a = 1'b0;
  logic dtc_b = 1'b0;
  logic sel_a = 1'b0;
  logic [15:0] counter, x1, x2, ea;
  logic pin_a, pin_b, ch3a, ch3c, a_out, a_oe, b_out, b_oe, irq_a, irq_b, adc_start;
  logic [7:0] adc_count = 8'h00;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  logic [7:0] rst_addr [5] = '{ADDR_IO_CTRL, ADDR_STATUS, ADDR_GEN_A, ADDR_GEN_B, 8'h18};
  logic [31:0] rst_val [5] = '{{24'h0, IO_CTRL_RST}, {24'h0, STATUS_RST}, {16'h0, GEN_RST},
    {16'h0, GEN_RST}, PRDATA_UNMAPPED};

  always #12.5 pclk = ~pclk;

  ch4_far_model far (.pclk(pclk), .presetn(presetn), .run(run), .load(load),
    .load_val(load_val), .pin_a_drv(pin_a_drv), .pin_b_drv(pin_b_drv), .ev_a_req(ev_a_req),
    .ev_c_req(ev_c_req), .counter(counter), .pin_a(pin_a), .pin_b(pin_b),
    .ch3_event_a(ch3a), .ch3_event_c(ch3c));

  ch4_cc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_counter(counter), .count_direction_flag(1'b1),
    .overflow_evt(1'b0), .underflow_evt(1'b0), .ch3_event_a(ch3a), .ch3_event_c(ch3c),
    .dtc_start_a(dtc_a), .dtc_start_b(dtc_b), .transfer_irq_disable_select_a(sel_a),
    .transfer_irq_disable_select_b(sel_a), .ch4_pin_a_in(a_oe ? a_out : pin_a),
    .ch4_pin_b_in(b_oe ? b_out : pin_b), .ch4_pin_a_out(a_out), .ch4_pin_a_oe(a_oe),
    .ch4_pin_b_out(b_out), .ch4_pin_b_oe(b_oe), .match_capture_irq_a(irq_a),
    .match_capture_irq_b(irq_b), .adc_start(adc_start));

  always_ff @(posedge pclk) begin
    if (adc_start === 1'b1) begin
      adc_count <= adc_count + 8'h01;
    end
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test;
    end
  end

  // ****************
  // Bus and stimulus helpers
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setcnt(input logic [15:0] v);
    @(posedge pclk);
    load <= 1'b1;
    load_val <= v;
    @(posedge pclk);
    load <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    void'($urandom(18));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, rst_addr[i], 32'h0);
      `CHK("reset value", rst_val[i], q)
    end
    `CHK("unmapped error", 1'b1, serr)
    // ****************
    // Compare on both registers
    // ****************
    for (i = 0; i < 2; i++) begin
      x1 = 16'h0100 + 16'($urandom_range(3, 9));
      setcnt(16'h0100);
      apb(1'b1, ADDR_GEN_A, {16'h0, x1});
      apb(1'b1, ADDR_GEN_B, {16'h0, x1 + 16'h0002});
      apb(1'b1, ADDR_ADC_CTRL, 32'h80);
      apb(1'b1, ADDR_IO_CTRL, (i == 0) ? 32'h53 : 32'h72);
      repeat (2) @(posedge pclk);
      `CHK("pin a start", 2'b10, {a_oe, a_out})
      `CHK("pin b start", 2'b11, {b_oe, b_out})
      run <= 1'b1;
      repeat (20) @(posedge pclk);
      run <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("pin a high", 1'b1, a_out)
      `CHK("pin b low", 1'b0, b_out)
      `CHK("adc pulses", 8'(i + 1), adc_count)
      apb(1'b1, ADDR_STATUS, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'hFF);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK("flags kept", 32'hC3, q)
      apb(1'b1, ADDR_STATUS, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK("flags cleared", 32'hC0, q)
    end
    // ****************
    // Chained capture and transfer clears
    // ****************
    apb(1'b1, ADDR_ADC_CTRL, 32'h0);
    apb(1'b1, ADDR_IO_CTRL, 32'hCC);
    x1 = 16'($urandom);
    setcnt(x1);
    ev_a_req <= 1'b1;
    @(posedge pclk);
    ev_a_req <= 1'b0;
    apb(1'b0, ADDR_GEN_A, 32'h0);
    `CHK("chain a", {16'h0, x1}, q)
    `CHK("flag a", 1'b1, irq_a)
    x2 = 16'($urandom);
    setcnt(x2);
    ev_c_req <= 1'b1;
    @(posedge pclk);
    ev_c_req <= 1'b0;
    apb(1'b0, ADDR_GEN_B, 32'h0);
    `CHK("chain b", {16'h0, x2}, q)
    `CHK("flag b", 1'b1, irq_b)
    `CHK("adc blocked", 8'h02, adc_count)
    sel_a <= 1'b1;
    dtc_a <= 1'b1;
    dtc_b <= 1'b1;
    @(posedge pclk);
    dtc_a <= 1'b0;
    dtc_b <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("flag a kept", 1'b1, irq_a)
    `CHK("flag b kept", 1'b1, irq_b)
    sel_a <= 1'b0;
    dtc_a <= 1'b1;
    dtc_b <= 1'b1;
    @(posedge pclk);
    dtc_a <= 1'b0;
    dtc_b <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("flag a dtc", 1'b0, irq_a)
    `CHK("flag b dtc", 1'b0, irq_b)
    // ****************
    // Pin edge capture: rise, fall, both
    // ****************
    ea = x1;
    for (i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_IO_CTRL, {24'h0, 4'(8 + i), 4'(8 + i)});
      x1 = 16'($urandom);
      setcnt(x1);
      pin_a_drv <= 1'b1;
      pin_b_drv <= 1'b1;
      repeat (8) @(posedge pclk);
      ea = (i != 1) ? x1 : ea;
      x2 = 16'($urandom);
      setcnt(x2);
      pin_a_drv <= 1'b0;
      pin_b_drv <= 1'b0;
      repeat (8) @(posedge pclk);
      ea = (i != 0) ? x2 : ea;
      apb(1'b0, ADDR_GEN_A, 32'h0);
      `CHK("capture a", {16'h0, ea}, q)
      apb(1'b0, ADDR_GEN_B, 32'h0);
      `CHK("capture b", {16'h0, ea}, q)
    end
    stop_test;
  end
endmodule // timer_ch4_capture_compare_ctrl_tb_top
